/* hdl/mmpc_pkg.sv */
// Package for the motor configuration word bank: offsets, field positions,
// reset values, lookup tables and the decoded-configuration carrier.
// Assumes a 32-bit register port with byte offsets.
package mmpc_pkg;

    localparam logic [7:0]  MMPC_OFF_MISC = 8'h58;
    localparam logic [7:0]  MMPC_OFF_PIN  = 8'h5C;
    localparam logic [7:0]  MMPC_OFF_PERI = 8'h60;

    localparam logic [31:0] MMPC_RESET_WORD = 32'h0000_0000;

    // Writable masks: reserved read-only bits are cleared here
    localparam logic [31:0] MMPC_MISC_WMASK = 32'hFFFF_FFC3;
    localparam logic [31:0] MMPC_PIN_WMASK  = 32'hFFFF_FFFF;
    localparam logic [31:0] MMPC_PERI_WMASK = 32'h0000_7FFF;

    // Field positions
    localparam int MMPC_ACC_LSB    = 6;
    localparam int MMPC_ACC_W      = 4;
    localparam int MMPC_HOLD_LSB   = 0;
    localparam int MMPC_HOLD_W     = 2;
    localparam int MMPC_FILT_BIT   = 19;
    localparam int MMPC_BMODE_BIT  = 2;
    localparam int MMPC_BIN_LSB    = 0;
    localparam int MMPC_BIN_W      = 2;
    localparam int MMPC_DEAD_LSB   = 9;
    localparam int MMPC_DEAD_W     = 6;
    localparam int MMPC_ILIM_LSB   = 4;
    localparam int MMPC_ILIM_W     = 5;
    localparam int MMPC_ILIM_EN    = 3;
    localparam int MMPC_DIN_LSB    = 1;
    localparam int MMPC_DIN_W      = 2;
    localparam int MMPC_DCHG_BIT   = 0;

    // Override codes shared by brake and direction fields
    localparam logic [1:0] MMPC_OVR_PIN_A = 2'h0;
    localparam logic [1:0] MMPC_OVR_ON    = 2'h1;
    localparam logic [1:0] MMPC_OVR_OFF   = 2'h2;

    // Timing: dead-time step in ns, clock period in ns
    localparam int MMPC_DEAD_STEP_NS = 50;
    localparam int MMPC_CLK_NS       = 8;
    // Longest-time rounding down, never below one cycle
    localparam int MMPC_DEAD_STEP_CYC =
        (MMPC_DEAD_STEP_NS / MMPC_CLK_NS) < 1 ? 1 : (MMPC_DEAD_STEP_NS / MMPC_CLK_NS);

    // Brake hold time per code in ms
    localparam logic [9:0] MMPC_HOLD_MS [4] = '{10'h032, 10'h064, 10'h0FA, 10'h1F4};

    // Acceleration per code, tenths of Hz/s
    localparam logic [15:0] MMPC_ACC_DHZ [16] = '{
        16'h0001, 16'h000A, 16'h0014, 16'h001E, 16'h0032, 16'h0064, 16'h00C8, 16'h012C,
        16'h0190, 16'h01F4, 16'h03E8, 16'h07D0, 16'h1388, 16'h1D4C, 16'h2710, 16'h4E20};

    // Bus current limit per code, tenths of a percent of base current
    localparam logic [9:0] MMPC_ILIM_PM [32] = '{
        10'h04B, 10'h050, 10'h055, 10'h05A, 10'h05F, 10'h064, 10'h06E, 10'h078,
        10'h082, 10'h08C, 10'h096, 10'h0A0, 10'h0AA, 10'h0B4, 10'h0C8, 10'h0E1,
        10'h0FA, 10'h113, 10'h12C, 10'h15E, 10'h190, 10'h1C2, 10'h1F4, 10'h226,
        10'h258, 10'h2BC, 10'h2EE, 10'h320, 10'h352, 10'h384, 10'h3B6, 10'h3E8};

    // Decoded configuration handed to the control loop
    typedef struct packed {
        logic [15:0] accel_dhz;
        logic [9:0]  brake_hold_ms;
        logic        bus_voltage_filter_bypass;
        logic [9:0]  bus_ilim_permille;
        logic        bus_ilim_active;
        logic        dir_change_reverse;
    } mmpc_cfg_t;

endpackage : mmpc_pkg

/* hdl/mmpc_config_bank.sv */
// Configuration word bank for a sensored motor controller: three words,
// field decoding, brake/direction override and a dead-time inserter.
// Assumes a synchronous register port on i_clock; brake and direction pins
// and the raw high-side command arrive from outside the clock domain.
//
// Summary of operation
// - Bits 9-6 of the misc word select the pre-alignment acceleration from 0.1 to 2000 Hz/s.
// - Bits 1-0 of the misc word select the brake low-current hold time of 50, 100, 250 or 500 ms.
// - The misc word at offset 58h resets to all zeros.
// - Pin word bit 19 low keeps the bus voltage filter on, high bypasses it.
// - Pin word bit 2 low selects low-side braking, high selects align braking.
// - Pin word bits 1-0 of 0 or 3 follow the brake pin, 1 forces braking, 2 forces none.
// - Dead time between high and low drive is 48 ns (six 8 ns cycles) times peripheral bits 14-9, or one 8 ns cycle when they are zero.
// - Peripheral bits 8-4 select the bus current limit from 7.5% to 100% of base current.
// - The bus current limit acts only while peripheral bit 3 is set.
// - Peripheral bits 2-1 of 0 or 3 follow the direction pin, 1 forces clockwise, 2 counter-clockwise.
// - On a direction change, bit 0 low requests stop and speed detect, high requests reverse drive.
`timescale 1ns/1ps
`default_nettype none

module mmpc_config_bank
    import mmpc_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic      [31:0] o_rdata,
    input  wire logic        i_brake_pin,
    input  wire logic        i_direction_pin,
    input  wire logic        i_high_cmd,
    output mmpc_cfg_t        o_cfg,
    output logic             o_brake_active,
    output logic             o_brake_align,
    output logic             o_dir_ccw,
    output logic             o_dir_change_pulse,
    output logic             o_stop_and_detect,
    output logic             o_reverse_drive,
    output logic             o_high_drive,
    output logic             o_low_drive
);

    // Reset release through two flops; the rest of the design uses rst_n
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Two-stage synchronisers for the asynchronous pins
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {i_high_cmd, i_direction_pin, i_brake_pin};
            pin_sync <= pin_meta;
        end
    end

    logic brake_pin_s;
    logic dir_pin_s;
    logic high_cmd_s;
    assign brake_pin_s = pin_sync[0];
    assign dir_pin_s   = pin_sync[1];
    assign high_cmd_s  = pin_sync[2];

    // Override decode shared by brake and direction fields
    function automatic logic ovr_select(input logic [1:0] code, input logic pin);
        case (code)
            MMPC_OVR_ON:  ovr_select = 1'b1;
            MMPC_OVR_OFF: ovr_select = 1'b0;
            default:      ovr_select = pin;
        endcase
    endfunction : ovr_select

    // Register words: next values
    logic [31:0] misc_algorithm_config;
    logic [31:0] pin_override_config;
    logic [31:0] peripheral_config;
    logic [31:0] next_misc;
    logic [31:0] next_pin;
    logic [31:0] next_peri;
    logic [31:0] next_rdata;

    always_comb begin
        next_misc  = misc_algorithm_config;
        next_pin   = pin_override_config;
        next_peri  = peripheral_config;
        next_rdata = 32'h0000_0000;  // Unmapped or idle reads return zero
        if (i_write) begin
            case (i_addr)
                MMPC_OFF_MISC: next_misc = i_wdata & MMPC_MISC_WMASK;
                MMPC_OFF_PIN:  next_pin  = i_wdata & MMPC_PIN_WMASK;
                MMPC_OFF_PERI: next_peri = i_wdata & MMPC_PERI_WMASK;
                default:       next_misc = misc_algorithm_config;
            endcase
        end
        if (i_read) begin
            case (i_addr)
                MMPC_OFF_MISC: next_rdata = misc_algorithm_config;
                MMPC_OFF_PIN:  next_rdata = pin_override_config;
                MMPC_OFF_PERI: next_rdata = peripheral_config;
                default:       next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Register words: storage, all zero after reset
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            misc_algorithm_config <= MMPC_RESET_WORD;
            pin_override_config   <= MMPC_RESET_WORD;
            peripheral_config     <= MMPC_RESET_WORD;
            o_rdata               <= 32'h0000_0000;
        end else begin
            misc_algorithm_config <= next_misc;
            pin_override_config   <= next_pin;
            peripheral_config     <= next_peri;
            o_rdata               <= next_rdata;
        end
    end

    // Field extraction
    logic [MMPC_ACC_W-1:0]  prealign_accel_rate;
    logic [MMPC_HOLD_W-1:0] brake_low_current_hold_time;
    logic [MMPC_DEAD_W-1:0] dead_code;
    logic [MMPC_ILIM_W-1:0] ilim_code;
    logic [MMPC_BIN_W-1:0]  brake_input;
    logic [MMPC_DIN_W-1:0]  dir_input;
    assign prealign_accel_rate         = misc_algorithm_config[MMPC_ACC_LSB +: MMPC_ACC_W];
    assign brake_low_current_hold_time = misc_algorithm_config[MMPC_HOLD_LSB +: MMPC_HOLD_W];
    assign dead_code   = peripheral_config[MMPC_DEAD_LSB +: MMPC_DEAD_W];
    assign ilim_code   = peripheral_config[MMPC_ILIM_LSB +: MMPC_ILIM_W];
    assign brake_input = pin_override_config[MMPC_BIN_LSB +: MMPC_BIN_W];
    assign dir_input   = peripheral_config[MMPC_DIN_LSB +: MMPC_DIN_W];

    // Decoded outputs: next values; the words are read live, so a write
    // shows up one cycle later with no reset needed
    mmpc_cfg_t next_cfg;
    logic      next_brake_active;
    logic      next_brake_align;
    logic      next_dir_ccw;

    always_comb begin
        next_cfg.accel_dhz                 = MMPC_ACC_DHZ[prealign_accel_rate];
        next_cfg.brake_hold_ms             = MMPC_HOLD_MS[brake_low_current_hold_time];
        next_cfg.bus_voltage_filter_bypass = pin_override_config[MMPC_FILT_BIT];
        next_cfg.bus_ilim_permille         = MMPC_ILIM_PM[ilim_code];
        next_cfg.bus_ilim_active           = peripheral_config[MMPC_ILIM_EN];
        next_cfg.dir_change_reverse        = peripheral_config[MMPC_DCHG_BIT];
        next_brake_active = ovr_select(brake_input, brake_pin_s);
        next_brake_align  = pin_override_config[MMPC_BMODE_BIT];
        next_dir_ccw      = ovr_select({dir_input[0], dir_input[1]}, dir_pin_s);
    end

    // Direction change detection and response selection
    logic prev_dir_ccw;
    logic next_change;
    logic next_stop;
    logic next_rev;
    always_comb begin
        next_change = rst_n && (next_dir_ccw != prev_dir_ccw);
        next_stop   = next_change && !peripheral_config[MMPC_DCHG_BIT];
        next_rev    = next_change &&  peripheral_config[MMPC_DCHG_BIT];
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_cfg              <= '0;
            o_brake_active     <= 1'b0;
            o_brake_align      <= 1'b0;
            o_dir_ccw          <= 1'b0;
            prev_dir_ccw       <= 1'b0;
            o_dir_change_pulse <= 1'b0;
            o_stop_and_detect  <= 1'b0;
            o_reverse_drive    <= 1'b0;
        end else begin
            o_cfg              <= next_cfg;
            o_brake_active     <= next_brake_active;
            o_brake_align      <= next_brake_align;
            o_dir_ccw          <= next_dir_ccw;
            prev_dir_ccw       <= next_dir_ccw;
            o_dir_change_pulse <= next_change;
            o_stop_and_detect  <= next_stop;
            o_reverse_drive    <= next_rev;
        end
    end

    // Dead-time inserter: each edge of the command turns both drives off,
    // then the new side waits dead_code steps; a code of zero still leaves one idle cycle
    localparam int DT_W = 16;
    logic [DT_W-1:0] dt_count;
    logic [DT_W-1:0] next_dt_count;
    logic            cmd_last;
    logic            next_high;
    logic            next_low;
    logic [DT_W-1:0] dt_load;
    assign dt_load = DT_W'(dead_code) * DT_W'(MMPC_DEAD_STEP_CYC);

    always_comb begin
        next_dt_count = dt_count;
        next_high     = 1'b0;
        next_low      = 1'b0;
        if (high_cmd_s != cmd_last) begin
            next_dt_count = dt_load;
        end else if (dt_count != '0) begin
            next_dt_count = dt_count - DT_W'(1);
        end
        if ((high_cmd_s == cmd_last) && (dt_count <= DT_W'(1))) begin
            next_high = high_cmd_s;
            next_low  = !high_cmd_s;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            dt_count     <= '0;
            cmd_last     <= 1'b0;
            o_high_drive <= 1'b0;
            o_low_drive  <= 1'b0;
        end else begin
            dt_count     <= next_dt_count;
            cmd_last     <= high_cmd_s;
            o_high_drive <= next_high;
            o_low_drive  <= next_low;
        end
    end

    // Checks
    AST_RESERVED_ZERO: assert property (@(posedge i_clock) disable iff (!rst_n)
        misc_algorithm_config[5:2] == 4'h0) else $error("misc reserved bits not zero");
    AST_MISC_READ: assert property (@(posedge i_clock) disable iff (!rst_n)
        (i_read && i_addr == MMPC_OFF_MISC) |=> o_rdata == $past(misc_algorithm_config))
        else $error("misc read mismatch");
    AST_FILTER: assert property (@(posedge i_clock) disable iff (!rst_n)
        (i_write && i_addr == MMPC_OFF_PIN) |-> ##2 o_cfg.bus_voltage_filter_bypass == $past(i_wdata[19], 2))
        else $error("filter bypass not applied");
    AST_BRAKE_FORCE: assert property (@(posedge i_clock) disable iff (!rst_n)
        (brake_input == MMPC_OVR_OFF) |=> !o_brake_active) else $error("brake not suppressed");
    AST_ILIM_EN: assert property (@(posedge i_clock) disable iff (!rst_n)
        !peripheral_config[MMPC_ILIM_EN] |=> !o_cfg.bus_ilim_active) else $error("limit active while off");
    AST_ACCEL: assert property (@(posedge i_clock) disable iff (!rst_n)
        (prealign_accel_rate == 4'hF) |=> o_cfg.accel_dhz == 16'h4E20) else $error("accel code wrong");
    AST_NO_OVERLAP: assert property (@(posedge i_clock) disable iff (!rst_n)
        !(o_high_drive && o_low_drive)) else $error("both drives on");
    AST_DEAD_OFF: assert property (@(posedge i_clock) disable iff (!rst_n)
        (high_cmd_s != cmd_last) |=> !(o_high_drive || o_low_drive)) else $error("drive not released on command edge");
    AST_DIR_RESP: assert property (@(posedge i_clock) disable iff (!rst_n)
        o_dir_change_pulse |-> (o_stop_and_detect != o_reverse_drive)) else $error("direction response bad");
    COV_DIR_REV: cover property (@(posedge i_clock) disable iff (!rst_n) o_reverse_drive);
    COV_DIR_STOP: cover property (@(posedge i_clock) disable iff (!rst_n) o_stop_and_detect);
    COV_BRAKE: cover property (@(posedge i_clock) disable iff (!rst_n) o_brake_active && o_brake_align);
    COV_DEAD: cover property (@(posedge i_clock) disable iff (!rst_n) dt_count > DT_W'(2));

endmodule : mmpc_config_bank

`default_nettype wire

/* sim/mmpc_far_model.sv */
// Far-side model: driver board pins and gate switches of the motor loop.
// Assumes the bench commands the pin levels; pins move just after an edge.
`timescale 1ns/1ps
`default_nettype none

module mmpc_far_model (
    input  wire logic i_clock,
    input  wire logic i_brake_lvl,
    input  wire logic i_dir_lvl,
    input  wire logic i_high_lvl,
    input  wire logic i_high_drive,
    input  wire logic i_low_drive,
    output logic      o_brake_pin,
    output logic      o_direction_pin,
    output logic      o_high_cmd,
    output logic      o_overlap
);
    // Known levels from time zero so the synchronisers never see unknowns
    initial begin
        o_brake_pin     = 1'b0;
        o_direction_pin = 1'b0;
        o_high_cmd      = 1'b0;
        o_overlap       = 1'b0;
    end

    // Board pins and sticky shoot-through flag: both switches on shorts the bus
    always @(posedge i_clock) begin
        o_brake_pin     <= i_brake_lvl;
        o_direction_pin <= i_dir_lvl;
        o_high_cmd      <= i_high_lvl;
        if (i_high_drive && i_low_drive) begin
            o_overlap <= 1'b1;
        end
    end
endmodule : mmpc_far_model

`default_nettype wire

/* sim/mmpc_config_bank_tb.sv */
// Testbench for the motor configuration word bank.
// Assumes the far-side pin model and a register port with one-cycle reads.
`timescale 1ns/1ps
`default_nettype none

module mmpc_config_bank_tb;
    import mmpc_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_reset_n, i_write, i_read;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic        brk_pin, dir_pin, high_cmd, brk_lvl, dir_lvl, high_lvl, overlap;
    logic        o_brake_active, o_brake_align, o_dir_ccw, o_dir_change_pulse;
    logic        o_stop_and_detect, o_reverse_drive, o_high_drive, o_low_drive;
    logic [2:0]  seen;
    mmpc_cfg_t   o_cfg;
    int          n_errors = 0, comparisons = 0, i, c, k, gap;
    int          acc_tab[16] = '{1, 10, 20, 30, 50, 100, 200, 300, 400, 500, 1000, 2000, 5000, 7500, 10000, 20000};
    int          hold_tab[4] = '{50, 100, 250, 500};
    int          ilim_tab[32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150, 160, 170, 180, 200, 225,
                                  250, 275, 300, 350, 400, 450, 500, 550, 600, 700, 750, 800, 850, 900, 950, 1000};

    mmpc_config_bank dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_brake_pin(brk_pin),
        .i_direction_pin(dir_pin), .i_high_cmd(high_cmd), .o_cfg(o_cfg), .o_brake_active(o_brake_active),
        .o_brake_align(o_brake_align), .o_dir_ccw(o_dir_ccw), .o_dir_change_pulse(o_dir_change_pulse),
        .o_stop_and_detect(o_stop_and_detect), .o_reverse_drive(o_reverse_drive),
        .o_high_drive(o_high_drive), .o_low_drive(o_low_drive));

    mmpc_far_model far_u (.i_clock(i_clock), .i_brake_lvl(brk_lvl), .i_dir_lvl(dir_lvl), .i_high_lvl(high_lvl),
        .i_high_drive(o_high_drive), .i_low_drive(o_low_drive), .o_brake_pin(brk_pin),
        .o_direction_pin(dir_pin), .o_high_cmd(high_cmd), .o_overlap(overlap));

    // 125 MHz system clock
    always #4 i_clock = ~i_clock;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One-cycle write strobe; the task leaves after lowering it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        chk("read data", exp, o_rdata);
    endtask : rdchk

    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : settle

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        report_and_stop();
    end

    initial begin
        {i_reset_n, i_write, i_read, i_addr, i_wdata} = '0;
        {brk_lvl, dir_lvl, high_lvl} = 3'h0;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        // Reset words, reserved bits and an unmapped place
        rdchk(MMPC_OFF_MISC, 32'h0000_0000);
        rdchk(MMPC_OFF_PIN, 32'h0000_0000);
        rdchk(MMPC_OFF_PERI, 32'h0000_0000);
        wr(MMPC_OFF_MISC, 32'hFFFF_FFFF);
        rdchk(MMPC_OFF_MISC, 32'hFFFF_FFC3);
        wr(8'h64, 32'hFFFF_FFFF);
        rdchk(8'h64, 32'h0000_0000);
        wr(MMPC_OFF_PIN, 32'hFFFF_FFFF);
        rdchk(MMPC_OFF_PIN, 32'hFFFF_FFFF);
        wr(MMPC_OFF_PERI, 32'hFFFF_FFFF);
        rdchk(MMPC_OFF_PERI, 32'h0000_7FFF);
        // Mid-run reset must bring every written word back to zero
        @(posedge i_clock);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        rdchk(MMPC_OFF_MISC, 32'h0000_0000);
        rdchk(MMPC_OFF_PIN, 32'h0000_0000);
        rdchk(MMPC_OFF_PERI, 32'h0000_0000);
        // Every acceleration and hold code, rewritten live without reset
        for (i = 0; i < 16; i++) begin
            wr(MMPC_OFF_MISC, 32'((i << 6) | (i % 4)));
            settle(4);
            chk("accel", acc_tab[i], o_cfg.accel_dhz);
            chk("hold", hold_tab[i % 4], o_cfg.brake_hold_ms);
        end
        // Brake override codes against brake pin and mode, filter bit alongside
        for (i = 0; i < 16; i++) begin
            c = i % 4;
            brk_lvl <= i[2];
            wr(MMPC_OFF_PIN, {12'h000, i[0], 16'h0000, i[3], c[1:0]});
            settle(6);
            chk("brake", (c == 1) ? 1 : (c == 2) ? 0 : i[2], o_brake_active);
            chk("align", i[3], o_brake_align);
            chk("filter", i[0], o_cfg.bus_voltage_filter_bypass);
        end
        // Every current limit code, enable and change mode alternating
        for (i = 0; i < 32; i++) begin
            wr(MMPC_OFF_PERI, {23'h000000, i[4:0], i[0], 2'h0, i[1]});
            settle(4);
            chk("ilim", ilim_tab[i], o_cfg.bus_ilim_permille);
            chk("ilim on", i[0], o_cfg.bus_ilim_active);
            chk("chg mode", i[1], o_cfg.dir_change_reverse);
        end
        // Direction override codes against the pin
        for (i = 0; i < 8; i++) begin
            c = i % 4;
            dir_lvl <= i[2];
            wr(MMPC_OFF_PERI, {29'h0, c[1:0], 1'b0});
            settle(6);
            chk("ccw", (c == 1) ? 0 : (c == 2) ? 1 : i[2], o_dir_ccw);
        end
        // Direction pin change under each change mode
        for (i = 0; i < 2; i++) begin
            wr(MMPC_OFF_PERI, 32'(i));
            settle(6);
            dir_lvl <= ~dir_lvl;
            seen = 3'h0;
            repeat (8) begin
                settle(1);
                if (o_dir_change_pulse === 1'b1) seen = {1'b1, o_stop_and_detect, o_reverse_drive};
            end
            chk("dir change", {1'b1, i == 0, i == 1}, seen);
        end
        // Dead time: both drives off for code times six cycles
        for (c = 1; c < 4; c += 2) begin
            wr(MMPC_OFF_PERI, 32'(c << 9));
            settle(40);
            high_lvl <= ~high_lvl;
            k = 0;
            while (k < 10 && (o_high_drive | o_low_drive) !== 1'b0) begin
                settle(1);
                k++;
            end
            gap = 0;
            while (gap < 40 && (o_high_drive | o_low_drive) === 1'b0) begin
                settle(1);
                gap++;
            end
            chk("dead gap", 1, gap >= c * 6 - 1 && gap <= c * 6 + 2);
            chk("new side", {high_lvl, ~high_lvl}, {o_high_drive, o_low_drive});
        end
        chk("overlap", 0, overlap);
        report_and_stop();
    end
endmodule : mmpc_config_bank_tb

`default_nettype wire
